// [core/cts_port.v]
// Codec serial data port: frame sync, shift clock, data pins and sync chain
`timescale 1ns/100ps
`default_nettype none
`include "cts_regs.vh"
module cts_port (
  input  wire        clock,              // Master clock, 200 MHz
  input  wire        sys_rst,            // Synchronous reset, active high
  input  wire        masterSel,          // Role select pin, high is master
  input  wire [3:0]  codecCount,         // Codecs in cascade minus one
  input  wire        shiftClkIn,         // Shift clock pin, input side
  output reg         shiftClkOut,        // Shift clock pin, output side
  output reg         shiftClkOe,         // Shift clock pin drive enable
  input  wire        frameSyncNIn,       // Frame sync pin, input side
  output reg         frameSyncNOut,      // Frame sync pin, output side
  output reg         frameSyncNOe,       // Frame sync pin drive enable
  input  wire        dataIn,             // Serial data input pin
  output reg         dataOut,            // Serial data output pin
  output reg         dataOutOe,          // Serial data output drive enable
  output reg         frame_sync_chain_out, // Delayed frame sync to next codec
  input  wire [15:0] txWord,             // Capture sample to send
  output reg         txTaken,            // Pulse: txWord loaded for a frame
  output reg  [15:0] rxWord,             // Last received playback word
  output reg         rxValid             // Pulse: rxWord updated
);
  // One-hot frame states
  localparam [2:0] ST_IDLE  = 3'b001;    // Waiting for frame start
  localparam [2:0] ST_SHIFT = 3'b010;    // Own slot in progress
  localparam [2:0] ST_DONE  = 3'b100;    // Slot finished, waiting for frame sync to rise

  wire        modeMaster;                // Synchronised role select
  wire        sclkPin;                   // Synchronised shift clock pin
  wire        fsPin;                     // Synchronised frame sync pin
  wire        dinPin;                    // Synchronised data pin

  reg  [`CTS_DIV_W-1:0] divCnt;          // Shift clock divider
  reg  [8:0]  framePos;                  // Bit position in master frame
  reg         genClk;                    // Generated shift clock level
  reg         genFs;                     // Generated frame sync level
  reg         prevSclk;                  // Previous internal shift clock
  reg         prevFs;                    // Previous internal frame sync
  reg  [2:0]  state;                     // Frame state
  reg  [4:0]  bitCnt;                    // Bits received in slot
  reg  [15:0] txShift;                   // Outgoing shift register
  reg  [15:0] rxShift;                   // Incoming shift register
  reg  [4:0]  chainCnt;                  // Chain low bits remaining

  wire        sclkLvl;                   // Shift clock seen by the port
  wire        fsLvl;                     // Frame sync seen by the port
  wire        sclkRise;                  // Rising shift clock edge
  wire        sclkFall;                  // Falling shift clock edge
  wire        fsFall;                    // Frame start
  wire        lastFall;                  // Falling edge that takes the last bit
  wire [8:0]  frameBits;                 // Shift clocks per master frame

  // Multiply cascade size by slot length
  function [8:0] slotsToBits;
    input [3:0] countMinusOne;
    begin
      slotsToBits = {1'b0, countMinusOne, 4'h0} + `CTS_SLOT_BITS;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  // Role select pin; reset takes slave so nothing drives early
  cts_sync uSyncMode (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .rstValue (1'b0),
    .asyncIn  (masterSel),
    .syncOut  (modeMaster)
  );
  // Shift clock pin
  cts_sync uSyncSclk (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .rstValue (1'b0),
    .asyncIn  (shiftClkIn),
    .syncOut  (sclkPin)
  );
  // Frame sync pin, idles high
  cts_sync uSyncFs (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .rstValue (1'b1),
    .asyncIn  (frameSyncNIn),
    .syncOut  (fsPin)
  );
  // Data pin; same delay as shift clock keeps them aligned
  cts_sync uSyncDin (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .rstValue (1'b0),
    .asyncIn  (dataIn),
    .syncOut  (dinPin)
  );

  ////////////////////////////////////////////////////////////////////////
  // Source selection and edge detection
  assign frameBits = slotsToBits(codecCount);
  assign sclkLvl   = modeMaster ? genClk : sclkPin;
  assign fsLvl     = modeMaster ? genFs : fsPin;
  assign sclkRise  = ~prevSclk & sclkLvl;
  assign sclkFall  = prevSclk & ~sclkLvl;
  assign fsFall    = prevFs & ~fsLvl;
  // Shared by the slot machine and the chain output
  assign lastFall  = sclkFall && dataOutOe && (bitCnt == `CTS_WORD_BITS - 1);

  // Edge history
  always @(posedge clock) begin
    if (sys_rst) begin
      prevSclk <= 1'b0;
      prevFs   <= 1'b1;
    end else begin
      prevSclk <= sclkLvl;
      prevFs   <= fsLvl;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Master clock and frame generator
  // Divided straight from the master clock, so no second clock tree
  always @(posedge clock) begin
    if (sys_rst || !modeMaster) begin
      divCnt   <= {`CTS_DIV_W{1'b0}};
      framePos <= `CTS_FRAME_POS_INIT;
      genClk   <= 1'b0;
      genFs    <= 1'b1;
    end else if (divCnt == `CTS_SCLK_HALF_CYC - 1) begin
      divCnt <= {`CTS_DIV_W{1'b0}};
      genClk <= ~genClk;
      // Frame sync changes with the falling edge, the same edge that samples data
      if (genClk) begin
        if (framePos == frameBits - 9'h001) begin
          framePos <= 9'h000;
          genFs    <= 1'b0;
        end else begin
          framePos <= framePos + 9'h001;
          // Held low over this codec's whole slot
          genFs    <= (framePos + 9'h001 >= `CTS_SLOT_BITS);
        end
      end
    end else begin
      divCnt <= divCnt + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin drivers for clock and frame sync; driven only as master
  always @(posedge clock) begin
    if (sys_rst) begin
      shiftClkOut   <= 1'b0;
      shiftClkOe    <= 1'b0;
      frameSyncNOut <= 1'b1;
      frameSyncNOe  <= 1'b0;
    end else begin
      shiftClkOut   <= genClk;
      shiftClkOe    <= modeMaster;
      frameSyncNOut <= genFs;
      frameSyncNOe  <= modeMaster;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Slot state machine and data shifting
  always @(posedge clock) begin
    if (sys_rst) begin
      state     <= ST_IDLE;
      bitCnt    <= 5'h00;
      txShift   <= 16'h0000;
      rxShift   <= 16'h0000;
      rxWord    <= 16'h0000;
      rxValid   <= 1'b0;
      txTaken   <= 1'b0;
      dataOut   <= 1'b0;
      dataOutOe <= 1'b0;
    end else begin
      rxValid <= 1'b0;
      txTaken <= 1'b0;
      case (state)
        ST_IDLE: begin
          dataOutOe <= 1'b0;
          if (fsFall) begin
            txShift <= txWord;
            txTaken <= 1'b1;
            bitCnt  <= 5'h00;
            state   <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          // Launch only while the frame is still low
          if (sclkRise && !fsLvl) begin
            dataOut   <= txShift[15];
            dataOutOe <= 1'b1;
            txShift   <= {txShift[14:0], 1'b0};
          end
          // Master frame sync rises on the edge of the last bit, so that bit still counts
          if (sclkFall && dataOutOe && (!fsLvl || lastFall)) begin
            rxShift <= {rxShift[14:0], dinPin};
            bitCnt  <= bitCnt + 5'h01;
            if (lastFall) begin
              rxWord  <= {rxShift[14:0], dinPin};
              rxValid <= 1'b1;
              state   <= ST_DONE;
            end
          end
          if (fsLvl && !lastFall) begin
            // Frame ended early; abandon the partial word
            dataOutOe <= 1'b0;
            state     <= ST_IDLE;
          end
        end
        ST_DONE: begin
          // Release the line at the next rising shift clock edge, or at once when frame sync is high
          if (sclkRise || fsLvl) begin
            dataOutOe <= 1'b0;
          end
          if (fsLvl) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          dataOutOe <= 1'b0;
          state     <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Delayed frame sync for the next codec in the cascade
  // Starts when our slot ends and lasts one slot, same as our frame low
  always @(posedge clock) begin
    if (sys_rst) begin
      chainCnt             <= 5'h00;
      frame_sync_chain_out <= 1'b1;
    end else if (state == ST_SHIFT && lastFall) begin
      chainCnt             <= `CTS_CHAIN_LOW;
      frame_sync_chain_out <= 1'b0;
    end else if (chainCnt != 5'h00 && sclkFall) begin
      chainCnt             <= chainCnt - 5'h01;
      frame_sync_chain_out <= (chainCnt == 5'h01);
    end
  end
endmodule // cts_port
`default_nettype wire

// [core/cts_regs.vh]
// Constants for the codec serial port pin logic
`ifndef CTS_REGS_VH
`define CTS_REGS_VH
// Bits in one codec time slot
`define CTS_SLOT_BITS      9'h010
// Width of a slot sample
`define CTS_WORD_BITS      16
// System clock period, ns
`define CTS_CLK_NS         5
// Master shift clock half period, ns
`define CTS_SCLK_HALF_NS   40
// Half period in system clock cycles, rounded down, at least one
`define CTS_SCLK_HALF_CYC  ((`CTS_SCLK_HALF_NS / `CTS_CLK_NS) < 1 ? 1 : (`CTS_SCLK_HALF_NS / `CTS_CLK_NS))
// Divider counter width
`define CTS_DIV_W          6
// Frame position one before zero, so the first master frame is whole
`define CTS_FRAME_POS_INIT 9'h1ff
// Shift clock falls that the chain output stays low
`define CTS_CHAIN_LOW      5'h10
`endif

// [core/cts_sync.v]
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module cts_sync (
  input  wire clock,      // System clock
  input  wire sys_rst,    // Synchronous reset, active high
  input  wire rstValue,   // Level taken during reset
  input  wire asyncIn,    // Input from outside the domain
  output reg  syncOut     // Filtered, synchronous level
);
  reg stage1;             // Metastability catcher, read by stage2 only
  reg stage2;             // Second stage
  reg stage3;             // Third stage

  ////////////////////////////////////////////////////////////////////////
  // Shift chain; output moves only when stages two and three agree
  always @(posedge clock) begin
    if (sys_rst) begin
      // Stages start at the idle level, so no false edge follows reset
      stage1  <= rstValue;
      stage2  <= rstValue;
      stage3  <= rstValue;
      syncOut <= rstValue;
    end else begin
      stage1 <= asyncIn;
      stage2 <= stage1;
      stage3 <= stage2;
      if (stage2 == stage3) begin
        syncOut <= stage3;  // Agreement: accept new level
      end
    end
  end
endmodule // cts_sync
`default_nettype wire

// [testbench/cts_port_properties.sv]
// Checker for the codec serial port pin timing
`timescale 1ns/100ps
`default_nettype none
module cts_port_properties (
  input wire logic clock,                // System clock
  input wire logic sys_rst,              // Synchronous reset
  input wire logic frameSyncNIn,         // Frame sync pin level
  input wire logic frameSyncNOut,        // Generated frame sync
  input wire logic frameSyncNOe,         // Frame sync drive
  input wire logic shiftClkOut,          // Generated shift clock
  input wire logic shiftClkOe,           // Shift clock drive
  input wire logic dataOutOe,            // Data pin drive
  input wire logic frame_sync_chain_out, // Delayed frame sync
  input wire logic txTaken,              // Word loaded
  input wire logic rxValid               // Word received
);
  logic [8:0] lowCnt;                    // Clocks of frame sync low so far
  ////////////////////////////////////////////////////////////////////////
  // Count low clocks; wraps only if a frame never ends
  always @(posedge clock) begin
    if (sys_rst || frameSyncNOut) lowCnt <= 9'h000;
    else lowCnt <= lowCnt + 9'h001;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // Shift clock holds for the rest of a half period
  sequence sHalfHold;
    (shiftClkOe && $stable(shiftClkOut)) [*7];
  endsequence
  a_out_floats_idle: assert property (frameSyncNIn [*8] |-> !dataOutOe)
    else $error("Data pin driven outside a frame");
  a_chain_follows_word: assert property (rxValid |-> ##[0:2] !frame_sync_chain_out)
    else $error("Chain output not low after word");
  a_valid_single: assert property (rxValid |=> !rxValid)
    else $error("Receive pulse too long");
  a_taken_single: assert property (txTaken |=> !txTaken)
    else $error("Load pulse too long");
  a_taken_slave_start: assert property ((!frameSyncNOe && $fell(frameSyncNIn)) |-> ##[4:6] txTaken)
    else $error("Slave frame start did not load a word");
  a_taken_master_start: assert property ((frameSyncNOe && $fell(frameSyncNIn)) |-> txTaken)
    else $error("Master frame start did not load a word");
  a_sclk_half_period: assert property ((shiftClkOe && $changed(shiftClkOut)) |=> sHalfHold ##1 $changed(shiftClkOut))
    else $error("Shift clock half period wrong");
  a_sync_low_clk: assert property ((frameSyncNOe && $fell(frameSyncNOut)) |-> !shiftClkOut)
    else $error("Frame sync fell with shift clock high");
  a_sync_low_len: assert property ((frameSyncNOe && $rose(frameSyncNOut)) |-> lowCnt == 9'h100)
    else $error("Frame sync low length wrong");
endmodule // cts_port_properties
bind cts_port cts_port_properties u_props (.clock(clock), .sys_rst(sys_rst), .frameSyncNIn(frameSyncNIn),
  .frameSyncNOut(frameSyncNOut), .frameSyncNOe(frameSyncNOe), .shiftClkOut(shiftClkOut), .shiftClkOe(shiftClkOe),
  .dataOutOe(dataOutOe), .frame_sync_chain_out(frame_sync_chain_out), .txTaken(txTaken), .rxValid(rxValid));
`default_nettype wire

// [testbench/cts_dsp_model.sv]
// Behavioural DSP serial port driving the codec as a slave
`timescale 1ns/100ps
`default_nettype none
module cts_dsp_model (
  output var logic        linkClk,   // Shift clock to codec
  output var logic        frameN,    // Frame sync to codec
  output var logic        serialOut, // Data to codec input
  input  wire logic       codecOut,  // Codec data output
  input  wire logic       codecOe,   // Codec data drive
  output var logic [15:0] heard      // Word taken from codec
);
  ////////////////////////////////////////////////////////////////////////
  // Idle: clock stands still, frame high
  initial begin
    linkClk = 1'b0;
    frameN = 1'b1;
    serialOut = 1'b0;
    heard = 16'h0000;
  end
  // One frame; an undriven pin reads as unknown so a float shows up
  task automatic sendFrame(input logic [15:0] word, input int nBits);
    frameN = 1'b0;
    #64;
    for (int i = 0; i < nBits; i++) begin
      linkClk = 1'b1;
      serialOut = word[15 - i];
      #32 linkClk = 1'b0;
      #30 heard = {heard[14:0], codecOe ? codecOut : 1'bx};
      #2;
    end
    #64 frameN = 1'b1;
    serialOut = ~serialOut; // Released line must not keep its value
  endtask
endmodule // cts_dsp_model
`default_nettype wire

// [testbench/test_cts_port.sv]
// Self-checking bench for the codec serial port pin logic
`timescale 1ns/100ps
`default_nettype none
module test_cts_port;
  logic        clock, sys_rst, masterSel;         // Clock, reset, role pin
  logic [3:0]  codecCount;                        // Cascade size minus one
  logic [15:0] txWord;                            // Capture word to send
  wire         shiftClkOut, shiftClkOe, frameSyncNOut, frameSyncNOe;
  wire         dataOut, dataOutOe, chainOut, txTaken, rxValid;
  wire  [15:0] rxWord, heard;                     // Words at both ends
  wire         linkClk, frameN, serialOut;        // Partner drives
  wire         shiftClkIn = shiftClkOe ? shiftClkOut : linkClk;     // Two-way pin level
  wire         frameSyncNIn = frameSyncNOe ? frameSyncNOut : frameN; // Two-way pin level
  int          failures, checked, cycles;         // Counters
  logic        sawValid, sawTaken, sawChain;      // Pulse catchers
  ////////////////////////////////////////////////////////////////////////
  cts_port uut (.clock(clock), .sys_rst(sys_rst), .masterSel(masterSel), .codecCount(codecCount),
    .shiftClkIn(shiftClkIn), .shiftClkOut(shiftClkOut), .shiftClkOe(shiftClkOe), .frameSyncNIn(frameSyncNIn),
    .frameSyncNOut(frameSyncNOut), .frameSyncNOe(frameSyncNOe), .dataIn(serialOut), .dataOut(dataOut),
    .dataOutOe(dataOutOe), .frame_sync_chain_out(chainOut), .txWord(txWord), .txTaken(txTaken),
    .rxWord(rxWord), .rxValid(rxValid));
  cts_dsp_model dsp (.linkClk(linkClk), .frameN(frameN), .serialOut(serialOut), .codecOut(dataOut),
    .codecOe(dataOutOe), .heard(heard));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // Catch one-cycle pulses; cut a hang short
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (rxValid === 1'b1) sawValid <= 1'b1;
    if (txTaken === 1'b1) sawTaken <= 1'b1;
    if (chainOut === 1'b0) sawChain <= 1'b1;
    if (cycles == 20000) begin
      failures++;
      wrap_up;
    end
  end
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Two frames back to back, edge bits set in both capture words
  task automatic test_slave_frames;
    logic [15:0] tx [2] = '{16'ha5c3, 16'h8001};
    logic [15:0] rx [2] = '{16'h3c96, 16'h0180};
    for (int i = 0; i < 2; i++) begin
      @(negedge clock);
      txWord = tx[i];
      {sawValid, sawTaken, sawChain} = 3'b000;
      dsp.sendFrame(rx[i], 16);
      repeat (8) @(negedge clock);
      check("capture word", tx[i], heard);
      check("playback word", rx[i], rxWord);
      check("receive pulse", 16'h0001, {15'h0000, sawValid});
      check("load pulse", 16'h0001, {15'h0000, sawTaken});
      check("chain low", 16'h0001, {15'h0000, sawChain});
      check("data floats", 16'h0000, {15'h0000, dataOutOe});
    end
    $display("slave frames done");
  endtask
  // Frame cut short after eight bits
  task automatic test_abort;
    @(negedge clock);
    sawValid = 1'b0;
    dsp.sendFrame(16'hffff, 8);
    repeat (8) @(negedge clock);
    check("abort pulse", 16'h0000, {15'h0000, sawValid});
    check("abort word", 16'h0180, rxWord);
    check("abort floats", 16'h0000, {15'h0000, dataOutOe});
    $display("abort done");
  endtask
  task automatic measure(input logic lvl, output int len);
    len = 0;
    while (frameSyncNOut === lvl && len < 4000) begin
      @(negedge clock);
      len++;
    end
  endtask
  // Master with two codecs: low 16 periods, high 16 periods
  task automatic test_master;
    int skip, lowLen, highLen;
    @(negedge clock);
    masterSel = 1'b1;
    codecCount = 4'h1;
    {sawValid, sawTaken} = 2'b00;
    repeat (8) @(negedge clock);
    measure(1'b0, skip);
    measure(1'b1, skip);
    measure(1'b0, lowLen);
    measure(1'b1, highLen);
    check("sync drive", 16'h0001, {15'h0000, frameSyncNOe});
    check("clock drive", 16'h0001, {15'h0000, shiftClkOe});
    check("frame low", 16'h0100, lowLen[15:0]);
    check("frame high", 16'h0100, highLen[15:0]);
    check("master receive", 16'h0001, {15'h0000, sawValid});
    check("master load", 16'h0001, {15'h0000, sawTaken});
    check("master word", 16'h0000, rxWord);
    $display("master done");
  endtask
  task automatic wrap_up;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    {sys_rst, masterSel, codecCount, txWord} = {1'b1, 1'b0, 4'h0, 16'h0000};
    {sawValid, sawTaken, sawChain} = 3'b000;
    {failures, checked, cycles} = {32'd0, 32'd0, 32'd0};
    repeat (2) @(negedge clock);
    sys_rst = 1'b0;
    repeat (10) @(negedge clock);
    test_slave_frames;
    test_abort;
    test_master;
    wrap_up;
  end
endmodule // test_cts_port
`default_nettype wire
